// >>> rtl/scs_pkg.sv
// Functional notes
// - One execution queue per interface, 32 entries deep, served in order.
// - Full queue: channel is accepted, transmit hand-over cell stays set until room.
// - Parameter channel from the queue runs its command word, no serial output.
// - 1 kbyte holding buffer keeps characters arriving with no input channel.
// - Linked input channel drains the holding buffer first, then takes characters directly.
// - Input mode low byte 08 discards the holding buffer; only newer characters delivered.
// - Scan function delivers buffered data to the end condition; empty buffer also ends.
// - Protocol function runs the registered receive routine instead of normal transfer.
// - With flow control, permission drops near 10% free and returns near 70% free.
// - Completion of a ready channel raises interrupt at channel level and vector; level zero suppresses it.
// - No new interrupt request while the current one is unacknowledged.
// - Channel time-out byte: bit 7 clear uses the interface time-out, else low bits times 10 ms.
// - Interface transmit and receive time-outs 0 to 32767 ms; zero disables.
// - Three interface timers: transmit, receive first character, receive between characters.
// - Each transfer activity restarts its time-out counter.
// - Time-out writes result 8007 and sets the transmit or receive time-out status bit.
// - Time-out status stays set; cleared only by status reset or channel reinitialisation, the receive bit also by the error mode command.
// - Time-out scraps non-waiting transmit; waiting transmit or receive becomes ready.
// - Break, parity, framing, overrun recorded in receive status; cleared by three commands.
// - Error mode: error flushes buffer when idle, else aborts receive with error code.
// - Simultaneous errors report one code: break, parity, framing, then overrun.
// - Non-zero hand-over cell means not absorbed; device clears it to zero when taken.
package scs_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_TIME = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * MS_TIME;
  localparam int STEP_MS = 10;
  localparam int QUEUE_DEPTH = 32;
  localparam int HOLD_BYTES = 1024;
  localparam int HOLD_OFF_PCT = 10;
  localparam int HOLD_ON_PCT = 70;

  localparam logic [23:0] ACK_ADDR = 24'h08601B;
  localparam logic [23:0] TX_TRIG_ADDR = 24'h080002;
  localparam logic [23:0] RX_TRIG_ADDR = 24'h080006;
  localparam logic [23:0] TX_CELL_ADDR = 24'h008080;
  localparam logic [23:0] RX_CELL_ADDR = 24'h0080C0;
  localparam logic [31:0] CELL_FREE = 32'h00000000;

  localparam logic [15:0] RES_TOUT = 16'h8007;
  localparam logic [15:0] RES_BREAK = 16'h8046;
  localparam logic [15:0] RES_PARITY = 16'h8020;
  localparam logic [15:0] RES_FRAMING = 16'h801E;
  localparam logic [15:0] RES_OVERRUN = 16'h801F;

  localparam logic [15:0] CMD_PARAM = 16'h0000;
  localparam logic [15:0] CMD_CLEAR = 16'h000C;
  localparam logic [15:0] CMD_RESET = 16'h000D;
  localparam logic [15:0] CMD_RSTAT = 16'h000E;
  localparam logic [15:0] CMD_RXOFF = 16'h0050;
  localparam logic [15:0] CMD_RXON = 16'h0051;
  localparam logic [15:0] CMD_RXERR = 16'h0052;
  localparam logic [15:0] CMD_SYNC = 16'hFFFF;

  localparam logic [7:0] MODE_DISCARD = 8'h08;
  localparam logic [31:0] FN_SCAN = 32'h5343414E;
  localparam logic [31:0] FN_PROT = 32'h50524F54;
  localparam logic [7:0] SCAN_END_CHAR = 8'h0D;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [3:0] ACK_RST = 4'h0;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] mode;
    logic [31:0] fname;
    logic [7:0] tout;
    logic [7:0] ilev;
    logic [7:0] ivec;
    logic [15:0] cmd;
    logic [15:0] len;
    logic is_param;
    logic wait_for_ready_flag;
  } scs_chan_t;

  typedef struct packed {
    logic [14:0] tx_timeout;
    logic [14:0] first_char_rx_timeout;
    logic [14:0] inter_char_rx_timeout;
    logic flow_en;
  } scs_cfg_t;

  typedef struct packed {
    logic brk;
    logic par;
    logic frm;
    logic ovr;
  } scs_rxerr_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [15:0] result;
    logic ready;
  } scs_done_t;

  typedef struct packed {
    logic req;
    logic [7:0] level;
    logic [7:0] vec;
  } scs_irq_t;

  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_FIN} scs_tx_st_t;
  typedef enum logic {RX_IDLE, RX_RUN} scs_rx_st_t;
endpackage

// >>> rtl/scs_hold_buf.sv
module scs_hold_buf import scs_pkg::*; #(
  parameter int DEPTH = HOLD_BYTES,
  parameter int AW = $clog2(DEPTH)
) (
  input logic clock,
  input logic rst_n,
  input logic flush,
  input logic push,
  input logic [7:0] din,
  input logic pop,
  output logic [7:0] dout,
  output logic [AW:0] count,
  output logic empty
);
  logic [7:0] mem [DEPTH];
  logic [AW:0] wp_ff;
  logic [AW:0] rp_ff;
  localparam logic [AW:0] FULL = DEPTH[AW:0];

  assign count = wp_ff - rp_ff;
  assign empty = count == '0;
  assign dout = mem[rp_ff[AW-1:0]];
  // A push into a full buffer is dropped; no status flag records that loss
  wire do_push = push && count != FULL;

  always_ff @(posedge clock) begin
    if (do_push) begin
      mem[wp_ff[AW-1:0]] <= din;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || flush) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      if (do_push) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (pop && !empty) begin
        rp_ff <= rp_ff + 1'b1;
      end
    end
  end
endmodule // scs_hold_buf

// >>> rtl/scs_server.sv
module scs_server import scs_pkg::*; #(
  parameter int QDEPTH = QUEUE_DEPTH,
  parameter int HOLD_DEPTH = HOLD_BYTES,
  parameter int MS_CYC = TICK_CYC
) (
  input logic clock,
  input logic rst_n,
  input logic host_wr,
  input logic [23:0] host_addr,
  input logic [31:0] host_wdata,
  input scs_chan_t host_chan,
  input scs_cfg_t cfg,
  input logic tx_byte_ready,
  input logic rx_char_valid,
  input logic [7:0] rx_char,
  input scs_rxerr_t rx_err,
  input logic prot_ret_valid,
  input logic [15:0] prot_ret,
  output logic [31:0] tx_handover_cell_ff,
  output logic [31:0] rx_handover_cell_ff,
  output logic tx_byte_valid_ff,
  output logic [15:0] tx_byte_idx_ff,
  output logic [31:0] tx_chan_addr,
  output logic rx_wr_valid_ff,
  output logic [15:0] rx_wr_idx_ff,
  output logic [7:0] rx_wr_data_ff,
  output logic [31:0] rx_chan_addr,
  output logic prot_run_ff,
  output scs_done_t tx_done_ff,
  output scs_done_t rx_done_ff,
  output scs_irq_t irq_ff,
  output logic [3:0] ack_pend_ff,
  output logic [7:0] txstat_ff,
  output logic [7:0] rxstat_ff,
  output logic errlog_ff,
  output logic rx_permit_ff
);
  localparam int QAW = $clog2(QDEPTH);
  localparam int HAW = $clog2(HOLD_DEPTH);
  localparam int TW = $clog2(MS_CYC) + 1;
  localparam logic [QAW:0] QFULL = QDEPTH[QAW:0];
  localparam int OFF_I = HOLD_DEPTH * HOLD_OFF_PCT / 100;
  localparam int ON_I = HOLD_DEPTH * HOLD_ON_PCT / 100;
  localparam logic [HAW:0] OFF_FREE = OFF_I[HAW:0];
  localparam logic [HAW:0] ON_FREE = ON_I[HAW:0];
  localparam logic [HAW:0] HOLD_SIZE = HOLD_DEPTH[HAW:0];
  localparam logic [TW-1:0] TICK_LAST = TW'(MS_CYC - 1);

  function automatic logic [15:0] tout_limit(input logic [7:0] t, input logic [14:0] g);
    tout_limit = t[7] ? 16'(t[6:0]) * 16'(STEP_MS) : {1'b0, g};
  endfunction

  function automatic logic [15:0] err_code(input scs_rxerr_t e);
    if (e.brk) begin
      return RES_BREAK;
    end else if (e.par) begin
      return RES_PARITY;
    end else if (e.frm) begin
      return RES_FRAMING;
    end
    return RES_OVERRUN;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Host writes: hand-over cells, triggers, acknowledge
  scs_chan_t tx_desc_ff, rx_desc_ff;
  logic tx_wake_ff, rx_wake_ff, tx_held_ff;
  scs_tx_st_t tx_st_ff;
  scs_rx_st_t rx_st_ff;
  scs_irq_t tx_irqp_ff, rx_irqp_ff;

  wire tx_cell_wr = host_wr && host_addr == TX_CELL_ADDR && tx_handover_cell_ff == CELL_FREE;
  wire rx_cell_wr = host_wr && host_addr == RX_CELL_ADDR && rx_handover_cell_ff == CELL_FREE;
  wire tx_trig = host_wr && host_addr == TX_TRIG_ADDR;
  wire rx_trig = host_wr && host_addr == RX_TRIG_ADDR;
  wire rx_absorb = rx_wake_ff && rx_handover_cell_ff != CELL_FREE && rx_st_ff == RX_IDLE && !rx_irqp_ff.req;
  wire [3:0] ack_bits = (host_wr && host_addr == ACK_ADDR) ? host_wdata[3:0] : 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit queue
  scs_chan_t q_mem [QDEPTH];
  logic [QAW:0] q_wp_ff, q_rp_ff;
  wire [QAW:0] q_cnt = q_wp_ff - q_rp_ff;
  wire q_full = q_cnt == QFULL;
  wire scs_chan_t q_head = q_mem[q_rp_ff[QAW-1:0]];
  wire tx_absorb = tx_wake_ff && tx_handover_cell_ff != CELL_FREE && !tx_held_ff;
  wire q_push = (tx_absorb || tx_held_ff) && !q_full;
  // Clear and reset act at hand-over time and drop what was still queued
  wire tx_imm = q_push && tx_desc_ff.is_param && (tx_desc_ff.cmd == CMD_CLEAR || tx_desc_ff.cmd == CMD_RESET);
  wire tx_pop = tx_st_ff == TX_IDLE && q_cnt != '0 && !tx_irqp_ff.req;
  wire [15:0] run_cmd = (tx_pop && q_head.is_param) ? q_head.cmd : CMD_SYNC;
  wire [15:0] imm_cmd = tx_imm ? tx_desc_ff.cmd : CMD_SYNC;
  wire cmd_rstat = run_cmd == CMD_RSTAT || imm_cmd == CMD_RESET;
  wire cmd_rxerr = run_cmd == CMD_RXERR;

  always_ff @(posedge clock) begin
    if (q_push) begin
      q_mem[q_wp_ff[QAW-1:0]] <= tx_desc_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q_wp_ff <= '0;
      q_rp_ff <= '0;
    end else begin
      q_wp_ff <= q_wp_ff + (QAW+1)'(q_push);
      q_rp_ff <= tx_imm ? q_wp_ff : q_rp_ff + (QAW+1)'(tx_pop);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_handover_cell_ff <= CELL_FREE;
      rx_handover_cell_ff <= CELL_FREE;
      tx_wake_ff <= 1'b0;
      rx_wake_ff <= 1'b0;
      tx_held_ff <= 1'b0;
    end else begin
      if (tx_cell_wr) begin
        tx_handover_cell_ff <= host_wdata;
        tx_desc_ff <= host_chan;
      end else if (q_push) begin
        tx_handover_cell_ff <= CELL_FREE;
      end
      if (rx_cell_wr) begin
        rx_handover_cell_ff <= host_wdata;
        rx_desc_ff <= host_chan;
      end else if (rx_absorb) begin
        rx_handover_cell_ff <= CELL_FREE;
      end
      tx_wake_ff <= tx_trig || (tx_wake_ff && !tx_absorb && tx_handover_cell_ff != CELL_FREE);
      rx_wake_ff <= rx_trig || (rx_wake_ff && !rx_absorb && rx_handover_cell_ff != CELL_FREE);
      tx_held_ff <= (tx_absorb && q_full) || (tx_held_ff && !q_push);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick shared by all timers
  logic [TW-1:0] tick_cnt_ff;
  wire tick = tick_cnt_ff == TICK_LAST;
  always_ff @(posedge clock) begin
    if (!rst_n || tick) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit server
  scs_chan_t tx_cur_ff;
  logic [15:0] tx_ms_ff, tx_res_ff;
  wire [15:0] tx_lim = tout_limit(tx_cur_ff.tout, cfg.tx_timeout);
  wire tx_to = tx_st_ff == TX_SEND && tx_lim != 16'h0000 && tx_ms_ff >= tx_lim;
  wire tx_acc = tx_byte_valid_ff && tx_byte_ready;
  wire tx_last = tx_byte_idx_ff + 16'h0001 == tx_cur_ff.len;
  wire tx_ready = tx_cur_ff.wait_for_ready_flag || tx_cur_ff.is_param;
  assign tx_chan_addr = tx_cur_ff.addr;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_st_ff <= TX_IDLE;
      tx_byte_valid_ff <= 1'b0;
      tx_byte_idx_ff <= 16'h0000;
      tx_ms_ff <= 16'h0000;
      tx_res_ff <= 16'h0000;
      tx_done_ff <= '0;
    end else begin
      tx_done_ff.valid <= 1'b0;
      if (tx_acc || tx_pop) begin
        tx_ms_ff <= 16'h0000;
      end else if (tick && tx_st_ff == TX_SEND && tx_lim != 16'h0000) begin
        tx_ms_ff <= tx_ms_ff + 16'h0001;
      end
      case (tx_st_ff)
        TX_IDLE: begin
          if (tx_pop) begin
            tx_cur_ff <= q_head;
            tx_byte_idx_ff <= 16'h0000;
            tx_res_ff <= q_head.len;
            if (q_head.is_param || q_head.len == 16'h0000) begin
              tx_st_ff <= TX_FIN;
            end else begin
              tx_st_ff <= TX_SEND;
              tx_byte_valid_ff <= 1'b1;
            end
          end
        end
        TX_SEND: begin
          if (tx_to) begin
            tx_byte_valid_ff <= 1'b0;
            tx_res_ff <= RES_TOUT;
            tx_st_ff <= TX_FIN;
          end else if (tx_acc) begin
            tx_byte_idx_ff <= tx_byte_idx_ff + 16'h0001;
            if (tx_last) begin
              tx_byte_valid_ff <= 1'b0;
              tx_st_ff <= TX_FIN;
            end
          end
        end
        TX_FIN: begin
          tx_done_ff <= '{valid: 1'b1, addr: tx_cur_ff.addr, result: tx_res_ff, ready: tx_ready};
          tx_st_ff <= TX_IDLE;
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive server and holding buffer
  scs_chan_t rx_ch_ff;
  logic rx_on_ff, rx_first_ff;
  logic [15:0] rx_idx_ff, rx_ms_ff;
  logic [4:0] rx_sticky_ff;
  logic tx_tout_ff;
  logic [7:0] hold_dout;
  logic [HAW:0] hold_cnt;
  logic hold_empty;

  wire rx_disc = rx_absorb && rx_desc_ff.mode[7:0] == MODE_DISCARD;
  wire rx_run = rx_st_ff == RX_RUN;
  wire is_prot = rx_ch_ff.fname == FN_PROT;
  wire is_scan = rx_ch_ff.fname == FN_SCAN;
  wire rx_normal = rx_run && !is_prot && !is_scan;
  wire cv = rx_char_valid && rx_on_ff;
  wire err_any = cv && |rx_err;
  wire err_abort = errlog_ff && err_any && rx_run;
  wire err_flush = errlog_ff && err_any && !rx_run;
  wire hold_pop = rx_run && !is_prot && !hold_empty && !err_abort;
  wire direct = rx_normal && hold_empty && cv && !err_abort;
  wire hold_push = cv && !direct && !(errlog_ff && err_any);
  wire hold_flush = tx_imm || rx_disc || err_flush;
  wire rx_wr = hold_pop || direct;
  wire [7:0] rx_data = hold_pop ? hold_dout : rx_char;
  wire [15:0] rx_cnt = rx_idx_ff + 16'(rx_wr);
  wire rx_last = rx_wr && rx_cnt == rx_ch_ff.len;
  wire scan_end = rx_run && is_scan && ((hold_pop && hold_dout == SCAN_END_CHAR) || hold_empty);
  wire prot_fin = rx_run && is_prot && prot_ret_valid && prot_ret != 16'h0000;
  wire [14:0] rx_glob = rx_first_ff ? cfg.first_char_rx_timeout : cfg.inter_char_rx_timeout;
  wire [15:0] rx_lim = tout_limit(rx_ch_ff.tout, rx_glob);
  wire rx_to = rx_run && rx_lim != 16'h0000 && rx_ms_ff >= rx_lim;
  wire rx_fin = rx_run && (err_abort || rx_to || prot_fin || rx_last || scan_end);
  wire [15:0] rx_res = err_abort ? err_code(rx_err) : rx_to ? RES_TOUT : prot_fin ? prot_ret : rx_cnt;
  wire [HAW:0] hold_free = HOLD_SIZE - hold_cnt;
  assign rx_chan_addr = rx_ch_ff.addr;

  scs_hold_buf #(.DEPTH(HOLD_DEPTH), .AW(HAW)) u_hold (
    .clock(clock),
    .rst_n(rst_n),
    .flush(hold_flush),
    .push(hold_push),
    .din(rx_char),
    .pop(hold_pop),
    .dout(hold_dout),
    .count(hold_cnt),
    .empty(hold_empty)
  );

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_st_ff <= RX_IDLE;
      rx_idx_ff <= 16'h0000;
      rx_ms_ff <= 16'h0000;
      rx_first_ff <= 1'b1;
      rx_wr_valid_ff <= 1'b0;
      rx_wr_idx_ff <= 16'h0000;
      rx_wr_data_ff <= 8'h00;
      prot_run_ff <= 1'b0;
      rx_done_ff <= '0;
    end else begin
      rx_wr_valid_ff <= rx_wr && !rx_to;
      rx_wr_idx_ff <= rx_idx_ff;
      rx_wr_data_ff <= rx_data;
      prot_run_ff <= rx_run && is_prot && hold_push;
      rx_done_ff.valid <= 1'b0;
      if (rx_wr || rx_absorb) begin
        rx_ms_ff <= 16'h0000;
      end else if (tick && rx_run && rx_lim != 16'h0000) begin
        rx_ms_ff <= rx_ms_ff + 16'h0001;
      end
      case (rx_st_ff)
        RX_IDLE: begin
          if (rx_absorb) begin
            rx_ch_ff <= rx_desc_ff;
            rx_idx_ff <= 16'h0000;
            rx_first_ff <= 1'b1;
            rx_st_ff <= RX_RUN;
          end
        end
        RX_RUN: begin
          rx_idx_ff <= rx_cnt;
          if (rx_wr) begin
            rx_first_ff <= 1'b0;
          end
          if (rx_fin) begin
            rx_done_ff <= '{valid: 1'b1, addr: rx_ch_ff.addr, result: rx_res, ready: 1'b1};
            rx_st_ff <= RX_IDLE;
          end
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, receiver mode and flow control
  wire [4:0] rx_set = {err_any ? {rx_err.brk, rx_err.par, rx_err.frm, rx_err.ovr} : 4'h0, rx_to};
  wire [4:0] nxt_rx_sticky = (rx_sticky_ff & ~{5{cmd_rstat || cmd_rxerr}}) | rx_set;
  wire nxt_tx_tout = (tx_tout_ff && !cmd_rstat) || tx_to;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_sticky_ff <= 5'h00;
      tx_tout_ff <= 1'b0;
      rx_on_ff <= 1'b1;
      errlog_ff <= 1'b0;
      rx_permit_ff <= 1'b1;
      txstat_ff <= STAT_RST;
      rxstat_ff <= STAT_RST;
    end else begin
      rx_sticky_ff <= nxt_rx_sticky;
      tx_tout_ff <= nxt_tx_tout;
      if (imm_cmd == CMD_RESET || run_cmd == CMD_RXON || cmd_rxerr) begin
        rx_on_ff <= 1'b1;
      end else if (run_cmd == CMD_RXOFF) begin
        rx_on_ff <= 1'b0;
      end
      if (cmd_rxerr) begin
        errlog_ff <= 1'b1;
      end else if (imm_cmd == CMD_RESET || run_cmd == CMD_RXON || run_cmd == CMD_RXOFF) begin
        errlog_ff <= 1'b0;
      end
      // Hysteresis keeps the handshake from chattering near the threshold
      if (!cfg.flow_en || hold_free >= ON_FREE) begin
        rx_permit_ff <= 1'b1;
      end else if (hold_free <= OFF_FREE) begin
        rx_permit_ff <= 1'b0;
      end
      txstat_ff <= {4'h0, nxt_tx_tout, q_full || tx_held_ff, 2'b00};
      rxstat_ff <= {nxt_rx_sticky, !hold_empty, !rx_permit_ff, !rx_on_ff};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus interrupt request and acknowledge
  wire busy = |ack_pend_ff;
  wire grant_rx = !busy && rx_irqp_ff.req;
  wire grant_tx = !busy && !rx_irqp_ff.req && tx_irqp_ff.req;
  wire scs_irq_t grant = grant_rx ? rx_irqp_ff : tx_irqp_ff;
  wire [3:0] ack_set = (grant_rx || grant_tx) ? 4'(1) << grant.vec[1:0] : 4'h0;
  wire [3:0] nxt_ack = (ack_pend_ff & ~ack_bits) | ack_set;
  wire tx_want = tx_st_ff == TX_FIN && tx_ready && tx_cur_ff.ilev != 8'h00;
  wire rx_want = rx_fin && rx_ch_ff.ilev != 8'h00;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_irqp_ff <= '0;
      rx_irqp_ff <= '0;
      irq_ff <= '0;
      ack_pend_ff <= ACK_RST;
    end else begin
      if (tx_want) begin
        tx_irqp_ff <= '{req: 1'b1, level: tx_cur_ff.ilev, vec: tx_cur_ff.ivec};
      end else if (grant_tx) begin
        tx_irqp_ff.req <= 1'b0;
      end
      if (rx_want) begin
        rx_irqp_ff <= '{req: 1'b1, level: rx_ch_ff.ilev, vec: rx_ch_ff.ivec};
      end else if (grant_rx) begin
        rx_irqp_ff.req <= 1'b0;
      end
      ack_pend_ff <= nxt_ack;
      if (grant_rx || grant_tx) begin
        irq_ff <= grant;
      end else begin
        irq_ff.req <= irq_ff.req && |nxt_ack;
      end
    end
  end
endmodule // scs_server

// >>> testbench/scs_server_sva.sv
module scs_server_sva import scs_pkg::*; (
  input logic clock,
  input logic rst_n,
  input logic host_wr,
  input logic [23:0] host_addr,
  input logic [31:0] host_wdata,
  input logic tx_byte_ready,
  input logic [31:0] tx_handover_cell_ff,
  input logic tx_byte_valid_ff,
  input logic [15:0] tx_byte_idx_ff,
  input scs_done_t tx_done_ff,
  input scs_done_t rx_done_ff,
  input scs_irq_t irq_ff,
  input logic [3:0] ack_pend_ff,
  input logic [7:0] txstat_ff,
  input logic [7:0] rxstat_ff
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire ack_wr = host_wr && host_addr == ACK_ADDR;
  //////////////////////////////////////////////////////////////
  property p_cell; $past(tx_handover_cell_ff) != CELL_FREE && $changed(tx_handover_cell_ff)
    |-> tx_handover_cell_ff == CELL_FREE; endproperty
  a_cell: assert property (p_cell) else $error("busy cell overwritten");
  property p_hold; tx_byte_valid_ff && !tx_byte_ready |=> !tx_byte_valid_ff || $stable(tx_byte_idx_ff); endproperty
  a_hold: assert property (p_hold) else $error("offered byte moved");
  property p_step; tx_byte_valid_ff && tx_byte_ready
    |=> !tx_byte_valid_ff || tx_byte_idx_ff == $past(tx_byte_idx_ff) + 16'h0001; endproperty
  a_step: assert property (p_step) else $error("bytes out of order");
  property p_lev; irq_ff.req |-> irq_ff.level != 8'h00; endproperty
  a_lev: assert property (p_lev) else $error("irq with level zero");
  property p_slot; $rose(irq_ff.req) |-> ##[0:1] ack_pend_ff[irq_ff.vec[1:0]]; endproperty
  a_slot: assert property (p_slot) else $error("wrong ack slot");
  property p_ack; ack_wr |=> (ack_pend_ff & $past(ack_pend_ff) & $past(host_wdata[3:0])) == 4'h0; endproperty
  a_ack: assert property (p_ack) else $error("ack bit not cleared");
  property p_drop; $past(ack_pend_ff) != 4'h0 && ack_pend_ff == 4'h0 |=> !irq_ff.req; endproperty
  a_drop: assert property (p_drop) else $error("irq kept after ack");
  property p_ttx; tx_done_ff.valid && tx_done_ff.result == RES_TOUT |-> ##[0:2] txstat_ff[3]; endproperty
  a_ttx: assert property (p_ttx) else $error("tx timeout flag missing");
  property p_trx; rx_done_ff.valid && rx_done_ff.result == RES_TOUT |-> ##[0:2] rxstat_ff[3]; endproperty
  a_trx: assert property (p_trx) else $error("rx timeout flag missing");
endmodule // scs_server_sva

bind scs_server scs_server_sva i_scs_server_sva (.*);

// >>> testbench/scs_line_model.sv
module scs_line_model (
  input logic clock,
  input logic stall,
  input logic fast,
  input logic tx_byte_valid_ff,
  output logic tx_byte_ready,
  output int taken
);
  timeunit 1ns;
  timeprecision 1ns;
  logic slow_ff = 1'b0;
  initial taken = 0;
  always @(posedge clock) begin
    slow_ff <= ~slow_ff;
    if (tx_byte_valid_ff && tx_byte_ready) begin
      taken <= taken + 1;
    end
  end
  // Slow mode takes every other cycle, so the offer must survive refusals
  assign tx_byte_ready = !stall && (fast || slow_ff);
endmodule // scs_line_model

// >>> testbench/tb.sv
module tb import scs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic host_wr = 1'b0;
  logic [23:0] host_addr = 24'h000000;
  logic [31:0] host_wdata = 32'h00000000;
  scs_chan_t host_chan = '0;
  scs_cfg_t cfg = {45'h0, 1'b1};
  logic stall = 1'b0;
  logic fast = 1'b0;
  logic tx_byte_ready;
  logic rx_char_valid = 1'b0;
  logic [7:0] rx_char = 8'h00;
  scs_rxerr_t rx_err = '0;
  logic [31:0] tx_cell, rx_cell;
  logic tx_byte_valid_ff, rx_wr_valid_ff, errlog_ff, rx_permit_ff;
  logic [15:0] tx_byte_idx_ff;
  logic [7:0] rx_wr_data_ff, txstat_ff, rxstat_ff;
  logic [3:0] ack_pend_ff;
  scs_done_t tx_done_ff, rx_done_ff;
  scs_irq_t irq_ff;
  int taken, fails, cmp_count, n, base;
  scs_chan_t c;
  scs_rxerr_t errs [4] = '{4'hF, 4'h7, 4'h3, 4'h1};
  logic [15:0] codes [4] = '{RES_BREAK, RES_PARITY, RES_FRAMING, RES_OVERRUN};
  logic [15:0] cmds [8] = '{CMD_RSTAT, CMD_PARAM, CMD_CLEAR, CMD_RESET, CMD_SYNC, CMD_RXERR, CMD_RXOFF, CMD_RXON};
  scs_server #(.MS_CYC(20), .HOLD_DEPTH(16)) i_scs_server (.*, .prot_ret_valid(1'b0), .prot_ret(16'h0000),
    .tx_handover_cell_ff(tx_cell), .rx_handover_cell_ff(rx_cell), .tx_chan_addr(), .rx_wr_idx_ff(), .rx_chan_addr(),
    .prot_run_ff());
  scs_line_model i_scs_line_model (.*);
  initial begin
    forever #25 clock = ~clock;
  end
  //////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [63:0] s, input logic [63:0] e, input string m);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    @(posedge clock);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge clock);
    host_wr <= 1'b0;
  endtask
  task automatic hand(input logic tx, input scs_chan_t ci);
    @(posedge clock) host_chan <= ci;
    wr(tx ? TX_CELL_ADDR : RX_CELL_ADDR, ci.addr);
    wr(tx ? TX_TRIG_ADDR : RX_TRIG_ADDR, 32'h00000000);
  endtask
  task automatic rxc(input logic [7:0] d, input scs_rxerr_t e);
    @(posedge clock);
    rx_char_valid <= 1'b1;
    rx_char <= d;
    rx_err <= e;
    @(posedge clock);
    rx_char_valid <= 1'b0;
  endtask
  task automatic wt(input int k, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (!hit && cnt < 3000) begin
      @(negedge clock);
      cnt++;
      hit = k == 0 ? tx_done_ff.valid === 1'b1 : k == 1 ? rx_done_ff.valid === 1'b1 :
        k == 2 ? irq_ff.req === 1'b1 : rx_wr_valid_ff === 1'b1;
    end
    if (!hit) begin
      chk(0, 1, "wait ran out");
      conclude();
    end
  endtask
  function automatic scs_chan_t ch(input logic [15:0] len, input logic [7:0] to, input logic [7:0] lev,
    input logic [7:0] vec, input logic isp, input logic w, input logic [15:0] cmd);
    ch = '{32'h00009000, 16'h0000, 32'h00000000, to, lev, vec, cmd, len, isp, w};
  endfunction
  //////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(negedge clock);
    chk({ack_pend_ff, txstat_ff, rxstat_ff, irq_ff.req, rx_permit_ff, tx_cell | rx_cell}, 54'h100000000, "reset");
    hand(1'b1, ch(16'h0003, 8'h00, 8'h05, 8'h62, 1'b0, 1'b1, CMD_PARAM));
    wt(0, n);
    chk(taken, 3, "bytes sent");
    wt(2, n);
    chk({irq_ff.level, irq_ff.vec, ack_pend_ff}, {8'h05, 8'h62, 4'h4}, "irq fields");
    wr(ACK_ADDR, 32'h0);
    @(negedge clock);
    chk({irq_ff.req, ack_pend_ff}, 5'h14, "zero ack");
    wr(ACK_ADDR, 32'h4);
    repeat (2) @(negedge clock);
    chk({irq_ff.req, ack_pend_ff}, 5'h00, "ack");
    $display("test tx_irq done");
    @(posedge clock) stall <= 1'b1;
    hand(1'b1, ch(16'h0002, 8'h81, 8'h00, 8'h00, 1'b0, 1'b0, CMD_PARAM));
    wt(0, n);
    chk({tx_done_ff.result, tx_done_ff.ready}, {RES_TOUT, 1'b0}, "tx timeout");
    chk(n inside {[175:235]}, 1'b1, "tx timeout time");
    @(posedge clock) stall <= 1'b0;
    hand(1'b1, ch(16'h0001, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, CMD_PARAM));
    wt(0, n);
    @(negedge clock);
    chk(txstat_ff[3], 1'b1, "sticky");
    $display("test tx_timeout done");
    fast <= 1'b1;
    base = taken;
    foreach (cmds[i]) begin
      hand(1'b1, ch(16'h0002, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, cmds[i]));
      wt(0, n);
      repeat (2) @(negedge clock);
      chk({taken, txstat_ff[3]}, {base, 1'b0}, "param output");
      chk({errlog_ff, rxstat_ff[0]}, {cmds[i] == CMD_RXERR, cmds[i] == CMD_RXOFF}, "cmd");
    end
    $display("test commands done");
    for (int i = 0; i < 15; i++) rxc(8'h10 + 8'(i), '0);
    repeat (2) @(negedge clock);
    chk({rx_permit_ff, rxstat_ff[2]}, 2'b01, "nearly full");
    hand(1'b0, ch(16'h000F, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, CMD_PARAM));
    for (int i = 0; i < 15; i++) begin
      wt(3, n);
      chk(rx_wr_data_ff, 8'h10 + i, "drain order");
    end
    chk({rx_done_ff.valid, rx_done_ff.result}, {1'b1, 16'h000F}, "rx count");
    repeat (2) @(negedge clock);
    chk({rx_permit_ff, rxstat_ff[2], irq_ff.req}, 3'b100, "drained");
    $display("test flow done");
    rxc(8'hA1, '0);
    c = ch(16'h0001, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, CMD_PARAM);
    c.mode = {8'h00, MODE_DISCARD};
    hand(1'b0, c);
    repeat (4) @(posedge clock);
    rxc(8'h55, '0);
    wt(3, n);
    chk({rx_wr_data_ff, rx_done_ff.valid}, {8'h55, 1'b1}, "discard");
    $display("test discard done");
    @(posedge clock) cfg.first_char_rx_timeout <= 15'd3;
    hand(1'b0, ch(16'h0002, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, CMD_PARAM));
    wt(1, n);
    chk({rx_done_ff.result, rx_done_ff.ready}, {RES_TOUT, 1'b1}, "rx timeout");
    chk(n inside {[35:85]}, 1'b1, "rx timeout time");
    $display("test rx_timeout done");
    hand(1'b1, ch(16'h0000, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, CMD_RXERR));
    wt(0, n);
    foreach (errs[i]) begin
      hand(1'b0, ch(16'h0004, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, CMD_PARAM));
      repeat (3) @(posedge clock);
      rxc(8'h33, errs[i]);
      wt(1, n);
      chk(rx_done_ff.result, codes[i], "error code");
    end
    rxc(8'h44, '0);
    rxc(8'h45, 4'h2);
    repeat (2) @(negedge clock);
    chk({rxstat_ff[5], rxstat_ff[2]}, 2'b10, "idle flush");
    $display("test errors done");
    conclude();
  end
endmodule // tb
